/* File: inc/sssu_pkg.sv */
// package: opcodes, widths and shift latency of the saturating shift/subtract unit
package sssu_pkg;
  localparam int WORD_W       = 32;  // integer operand width
  localparam int LONG_W       = 40;  // long operand width
  localparam int HALF_W       = 16;  // packed halfword width
  localparam int SHIFT_MAX    = 31;  // count clamp magnitude
  localparam int SHIFT_LAT    = 2;   // shift: execute stages to destination
  // operation select
  typedef enum logic [2:0] {
    SSSU_OP_NONE  = 3'h0,
    SSSU_OP_SHVL  = 3'h1,  // variable_shift_left_sat
    SSSU_OP_SHVR  = 3'h2,  // variable_shift_right_sat
    SSSU_OP_SUB32 = 3'h3,  // signed_subtract_sat, int result
    SSSU_OP_SUB40 = 3'h4,  // signed_subtract_sat, long result
    SSSU_OP_SUB2  = 3'h5   // dual_halfword_subtract_sat
  } sssu_op_t;
endpackage

/* File: inc/sssu_shift_if.sv */
// interface: request and answer between the top and the shift pipe
`timescale 1ns/1ns
interface sssu_shift_if;
  logic        req;     // shift issued, condition passed
  logic        right;   // right-shift variant
  logic [31:0] src2;    // value to shift
  logic [31:0] src1;    // signed shift count
  logic [4:0]  dst_idx; // destination tag
  logic        done;    // destination write pulse
  logic [31:0] result;  // shifted, saturated value
  logic [4:0]  res_idx; // destination tag of result
  logic        sat;     // result was clamped
  modport top  (output req, right, src2, src1, dst_idx,
                input done, result, res_idx, sat);
  modport pipe (input req, right, src2, src1, dst_idx,
                output done, result, res_idx, sat);
endinterface

/* File: rtl/sssu_shift_pipe.sv */
// two-stage saturating variable shift pipe
`timescale 1ns/1ns
module sssu_shift_pipe (
  input  wire logic   mclk,
  input  wire logic   arst_n,
  sssu_shift_if.pipe  sif
);
  // stage 1 registers
  logic        s1_v;
  logic [31:0] s1_res;
  logic [4:0]  s1_idx;
  logic        s1_sat;
  logic        next_s1_v;
  logic [31:0] next_s1_res;
  logic        next_s1_sat;
  // stage 2 registers drive the answer
  logic        s2_v;
  logic [31:0] s2_res;
  logic [4:0]  s2_idx;
  logic        s2_sat;

  // count clamp, direction, shift and saturate in stage one
  always_comb begin
    logic signed [31:0] cnt;
    logic signed [31:0] lim;
    logic [4:0]         mag;
    logic signed [63:0] wide;
    logic signed [31:0] sv;
    cnt  = signed'(sif.src1);
    lim  = 32'(sssu_pkg::SHIFT_MAX);
    mag  = 5'h00;
    wide = 64'h0;
    sv   = signed'(sif.src2);
    next_s1_sat = 1'b0;
    if (cnt > lim) begin
      cnt = lim;  // [RULE1] [RULE6]
    end else if (cnt < -lim) begin
      cnt = -lim;  // [RULE1] [RULE6]
    end
    // the right variant just inverts the count direction
    if (sif.right) begin
      cnt = -cnt;  // [RULE5]
    end
    if (cnt < 0) begin
      mag = 5'(-cnt);
      next_s1_res = 32'(sv >>> mag);  // [RULE2] [RULE5]
    end else begin
      mag  = 5'(cnt);
      wide = 64'(sv) <<< mag;
      // saturate unless the wide value fits in 32 signed bits
      if (wide > 64'sh0000_0000_7FFF_FFFF) begin
        next_s1_res = 32'h7FFF_FFFF;  // [RULE3] [RULE7]
        next_s1_sat = 1'b1;
      end else if (wide < -64'sh0000_0000_8000_0000) begin
        next_s1_res = 32'h8000_0000;  // [RULE3] [RULE7]
        next_s1_sat = 1'b1;
      end else begin
        next_s1_res = wide[31:0];  // [RULE3] [RULE7]
      end
    end
    next_s1_v = sif.req;
  end

  // pipe registers, destination leaves after stage two
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_v   <= 1'b0;
      s1_res <= 32'h0000_0000;
      s1_idx <= 5'h00;
      s1_sat <= 1'b0;
      s2_v   <= 1'b0;
      s2_res <= 32'h0000_0000;
      s2_idx <= 5'h00;
      s2_sat <= 1'b0;
    end else begin
      s1_v   <= next_s1_v;
      s1_res <= next_s1_res;
      s1_idx <= sif.dst_idx;
      s1_sat <= next_s1_sat & next_s1_v;
      s2_v   <= s1_v;  // [RULE15]
      s2_res <= s1_res;
      s2_idx <= s1_idx;
      s2_sat <= s1_sat;
    end
  end

  assign sif.done    = s2_v;
  assign sif.result  = s2_res;
  assign sif.res_idx = s2_idx;
  assign sif.sat     = s2_sat;
endmodule

/* File: rtl/sssu_top.sv */
// saturating shift and subtract datapath with sticky saturation flag
`timescale 1ns/1ns
// How it works
// RULE1: left shift clamps count to -31..31
// RULE2: left shift: positive left, negative arithmetic right
// RULE3: left shift saturates else truncates to 32
// RULE4: shift saturation sets sticky flag a cycle later
// RULE5: right shift: positive right, negative left
// RULE6: right shift clamps count to -31..31
// RULE7: right shift leftward result saturates to extremes
// RULE8: subtract first minus second, clamp to size
// RULE9: int result clamps to 32-bit extremes
// RULE10: long result clamps to 40-bit extremes
// RULE11: subtract clamp sets sticky flag a cycle later
// RULE12: dual subtract works on packed halfwords
// RULE13: each halfword saturates to 16-bit extremes
// RULE14: dual subtract never touches saturation flags
// RULE15: shifts take two cycles, subtracts one
// RULE16: failed condition means nothing written, no flags
module sssu_top (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire sssu_pkg::sssu_op_t op,         // operation issued this cycle
  input  wire logic              cond_pass,  // condition register test
  input  wire logic [39:0]       src1,       // first operand, long in 39:0
  input  wire logic [39:0]       src2,       // second operand
  input  wire logic [4:0]        dst_idx,    // destination register tag
  input  wire logic              sat_clr,    // clear of the sticky flag
  output logic                   wr_en,      // destination write pulse
  output logic [4:0]             wr_idx,     // destination tag
  output logic [39:0]            wr_data,    // destination value
  output logic                   wr_long,    // write is a 40-bit long
  output logic                   sat_flag,   // sticky saturation flag
  output logic                   sat_unit    // per-unit status event
);
  sssu_shift_if sif ();
  // single-cycle subtract result and pending flag
  logic        sub_v;
  logic [39:0] sub_res;
  logic [4:0]  sub_idx;
  logic        sub_long;
  logic        sub_sat;
  logic        next_sub_v;
  logic [39:0] next_sub_res;
  logic        next_sub_long;
  logic        next_sub_sat;
  // sticky flag state
  logic        sat_pend;   // write happened, flag set next cycle
  logic        next_sat_pend;
  logic        next_sat_flag;
  logic        is_shift;

  // a failed condition never reaches either unit
  assign is_shift = cond_pass && (op == sssu_pkg::SSSU_OP_SHVL ||
                                  op == sssu_pkg::SSSU_OP_SHVR);  // [RULE16]
  assign sif.req     = is_shift;
  assign sif.right   = (op == sssu_pkg::SSSU_OP_SHVR);
  assign sif.src2    = src2[31:0];
  assign sif.src1    = src1[31:0];
  assign sif.dst_idx = dst_idx;

  sssu_shift_pipe u_shift (
    .mclk   (mclk),
    .arst_n (arst_n),
    .sif    (sif)
  );

  // clamped packed halfword differences, one slice per half
  wire logic [31:0] half_res;

  // per-halfword differences; each half saturates on its own
  // and never feeds the sticky flag, unlike the 32/40-bit paths
  for (genvar h = 0; h < 2; h++) begin : g_half
    logic signed [16:0] dh;  // raw 17-bit halfword difference
    assign dh = 17'(signed'(src1[h*16 +: 16]))
              - 17'(signed'(src2[h*16 +: 16]));  // [RULE12]
    // clamp to the signed 16-bit extremes
    assign half_res[h*16 +: 16] =
      (dh > 17'sh0_7FFF)  ? 16'h7FFF :  // [RULE13]
      (dh < -17'sh0_8000) ? 16'h8000 :  // [RULE13]
      dh[15:0];
  end

  // subtract paths: 32-bit, 40-bit and dual halfword
  always_comb begin
    logic signed [40:0] d41;
    logic signed [32:0] d33;
    d41 = 41'(signed'(src1)) - 41'(signed'(src2));
    d33 = 33'(signed'(src1[31:0])) - 33'(signed'(src2[31:0]));
    next_sub_res  = 40'h00_0000_0000;
    next_sub_sat  = 1'b0;
    next_sub_long = 1'b0;
    next_sub_v    = cond_pass;  // [RULE16]
    case (op)
      sssu_pkg::SSSU_OP_SUB32: begin
        // int result: first minus second, clamp to 32 bits
        if (d33 > 33'sh0_7FFF_FFFF) begin
          next_sub_res = 40'h00_7FFF_FFFF;  // [RULE8] [RULE9]
          next_sub_sat = 1'b1;
        end else if (d33 < -33'sh0_8000_0000) begin
          next_sub_res = 40'h00_8000_0000;  // [RULE9]
          next_sub_sat = 1'b1;
        end else begin
          next_sub_res = {8'h00, d33[31:0]};
        end
      end
      sssu_pkg::SSSU_OP_SUB40: begin
        next_sub_long = 1'b1;
        if (d41 > 41'sh000_7F_FFFF_FFFF) begin
          next_sub_res = 40'h7F_FFFF_FFFF;  // [RULE8] [RULE10]
          next_sub_sat = 1'b1;
        end else if (d41 < -41'sh000_80_0000_0000) begin
          next_sub_res = 40'h80_0000_0000;  // [RULE10]
          next_sub_sat = 1'b1;
        end else begin
          next_sub_res = d41[39:0];
        end
      end
      sssu_pkg::SSSU_OP_SUB2: begin
        // halves arrive clamped; flags stay untouched
        next_sub_res = {8'h00, half_res};  // [RULE12] [RULE13]
        next_sub_sat = 1'b0;  // [RULE14]
      end
      default: begin
        next_sub_v = 1'b0;  // shifts or no operation
      end
    endcase
  end

  // sticky flag: set wins over a clear in the same cycle.
  // timeline: write cycle, then pending, then flag visible,
  // so the flag trails the register file update by one cycle.
  // the per-unit event is the pending stage, one cycle ahead.
  always_comb begin
    next_sat_pend = (sub_v && sub_sat) ||
                    (sif.done && sif.sat);  // [RULE4] [RULE11]
    next_sat_flag = sat_flag;
    if (sat_clr) begin
      next_sat_flag = 1'b0;
    end
    if (sat_pend) begin
      next_sat_flag = 1'b1;  // [RULE4] [RULE11]
    end
  end

  // subtract result register gives single-cycle latency
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sub_v    <= 1'b0;
      sub_res  <= 40'h00_0000_0000;
      sub_idx  <= 5'h00;
      sub_long <= 1'b0;
      sub_sat  <= 1'b0;
      sat_pend <= 1'b0;
      sat_flag <= 1'b0;
    end else begin
      sub_v    <= next_sub_v;  // [RULE15]
      sub_res  <= next_sub_res;
      sub_idx  <= dst_idx;
      sub_long <= next_sub_long;
      sub_sat  <= next_sub_sat;
      sat_pend <= next_sat_pend;
      sat_flag <= next_sat_flag;
    end
  end

  // write port; the subtract wins when both finish together.
  // the issuing pipeline avoids that collision by scheduling,
  // so a shift result would be lost rather than stall here.
  always_comb begin
    if (sub_v) begin
      wr_en   = 1'b1;
      wr_idx  = sub_idx;
      wr_data = sub_res;
      wr_long = sub_long;
    end else begin
      wr_en   = sif.done;
      wr_idx  = sif.res_idx;
      wr_data = {8'h00, sif.result};
      wr_long = 1'b0;
    end
  end

  // per-unit status event alongside the sticky flag
  assign sat_unit = sat_pend;
endmodule

/* File: tb/sssu_rf_model.sv */
// register file model that collects the unit's destination writes
`timescale 1ns/1ns
module sssu_rf_model (
  input wire logic        mclk,
  input wire logic        wr_en,
  input wire logic [4:0]  wr_idx,
  input wire logic [39:0] wr_data
);
  logic [39:0] regs [32];  // destination registers
  // write port; a lost or late pulse leaves the old value
  always @(posedge mclk) begin
    if (wr_en) regs[wr_idx] <= wr_data;
  end
endmodule

/* File: tb/sssu_top_sva.sv */
// port assertions for the saturating shift and subtract unit
`timescale 1ns/1ns
module sssu_top_sva (
  input wire logic               mclk,
  input wire logic               arst_n,
  input wire sssu_pkg::sssu_op_t op,
  input wire logic               cond_pass,
  input wire logic [39:0]        src1,
  input wire logic [39:0]        src2,
  input wire logic [4:0]         dst_idx,
  input wire logic               sat_clr,
  input wire logic               wr_en,
  input wire logic [4:0]         wr_idx,
  input wire logic [39:0]        wr_data,
  input wire logic               wr_long,
  input wire logic               sat_flag,
  input wire logic               sat_unit
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic        sub_i;  // subtract of any kind issued
  logic        shf_i;  // shift issued
  logic [32:0] t32;    // raw int difference
  logic [40:0] t40;    // raw long difference
  logic        ov32;   // int difference out of range
  logic [39:0] d32;    // clamped int difference
  logic [39:0] d40;    // clamped long difference
  // reference results, sign bit picks the extreme
  always_comb begin
    sub_i = cond_pass && op >= sssu_pkg::SSSU_OP_SUB32;
    shf_i = cond_pass && (op == sssu_pkg::SSSU_OP_SHVL ||
                          op == sssu_pkg::SSSU_OP_SHVR);
    t32 = {src1[31], src1[31:0]} - {src2[31], src2[31:0]};
    ov32 = t32[32] ^ t32[31];
    d32 = ov32 ? {8'h00, t32[32], {31{~t32[32]}}} : {8'h00, t32[31:0]};
    t40 = {src1[39], src1} - {src2[39], src2};
    d40 = (t40[40] ^ t40[39]) ? {t40[40], {39{~t40[40]}}} : t40[39:0];
  end
  AST_SUB_LAT: assert property (sub_i |=> wr_en && wr_idx == $past(dst_idx))
    else $error("subtract write not one cycle after issue");
  AST_SHF_LAT: assert property (shf_i |-> ##2 wr_en)
    else $error("shift write not two cycles after issue");
  AST_NOP: assert property (!sub_i && !shf_i && !$past(shf_i) |=> !wr_en)
    else $error("write without a passing issue");
  AST_SUB32: assert property (sub_i && op == sssu_pkg::SSSU_OP_SUB32
    |=> wr_data == $past(d32)) else $error("int subtract value wrong");
  AST_SUB40: assert property (sub_i && op == sssu_pkg::SSSU_OP_SUB40
    |=> wr_long && wr_data == $past(d40)) else $error("long subtract wrong");
  // write, then pending stage, then the flag: three edges on
  AST_SUB_SAT: assert property (sub_i && op == sssu_pkg::SSSU_OP_SUB32
    && ov32 |-> ##3 sat_flag) else $error("clamp did not set flag");
  AST_STICKY: assert property (sat_flag && !sat_clr |=> sat_flag)
    else $error("sticky flag dropped");
  // the unit event pulses in the cycle before the flag shows
  AST_UNIT: assert property ($rose(sat_flag) |-> $past(sat_unit))
    else $error("status event missing with flag");
  AST_DUAL: assert property (sub_i && op == sssu_pkg::SSSU_OP_SUB2
    && !$past(shf_i) ##2 !sat_flag && !sat_clr |=> !sat_flag)
    else $error("dual subtract touched flag");
endmodule
bind sssu_top sssu_top_sva i_sva (
  .mclk(mclk), .arst_n(arst_n), .op(op), .cond_pass(cond_pass),
  .src1(src1), .src2(src2), .dst_idx(dst_idx), .sat_clr(sat_clr),
  .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data), .wr_long(wr_long),
  .sat_flag(sat_flag), .sat_unit(sat_unit)
);

/* File: tb/tb_sssu_top.sv */
// self-checking bench for the saturating shift and subtract unit
`timescale 1ns/1ns
module tb_sssu_top;
  logic               mclk, arst_n, cond_pass, sat_clr;
  logic               wr_en, wr_long, sat_flag, sat_unit;
  sssu_pkg::sssu_op_t op, o;
  logic [39:0]        src1, src2, wr_data;
  logic [4:0]         dst_idx, wr_idx;
  int                 n_mismatch, checks_done;
  sssu_top i_dut (
    .mclk(mclk), .arst_n(arst_n), .op(op), .cond_pass(cond_pass),
    .src1(src1), .src2(src2), .dst_idx(dst_idx), .sat_clr(sat_clr),
    .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data), .wr_long(wr_long),
    .sat_flag(sat_flag), .sat_unit(sat_unit)
  );
  sssu_rf_model i_rf (
    .mclk(mclk), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data)
  );
  // free-running core clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // compare and count
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // clear flag, issue one op, drain, judge register and flag
  task automatic run(input logic [39:0] a, b, r, input logic f,
                     input logic c = 1'b1);
    sat_clr = 1'b1;
    @(posedge mclk);
    #1;
    sat_clr = 1'b0;
    op = o;
    cond_pass = c;
    src1 = a;
    src2 = b;
    if (c) dst_idx = dst_idx + 5'h01;
    @(posedge mclk);
    #1;
    op = sssu_pkg::SSSU_OP_NONE;
    repeat (4) @(posedge mclk);
    #1;
    chk(i_rf.regs[dst_idx], r);
    chk({39'h0, sat_flag}, {39'h0, f});
  endtask
  // both shifts, clamped counts, saturation both ways
  task automatic test_shift;
    o = sssu_pkg::SSSU_OP_SHVL;
    run(40'hFFFFFFE1, 40'hFFFFF000, 40'hFFFFFFFF, 1'b0);
    run(40'h0000001F, 40'hF14C2108, 40'h80000000, 1'b1);
    run(40'h00000064, 40'h00000001, 40'h7FFFFFFF, 1'b1);
    o = sssu_pkg::SSSU_OP_SHVR;
    run(40'hFFFFFFE1, 40'hFFFFF000, 40'h80000000, 1'b1);
    run(40'hFFFFFF9C, 40'h00000001, 40'h7FFFFFFF, 1'b1);
    run(40'h0000001F, 40'hF14C2108, 40'hFFFFFFFF, 1'b0);
  endtask
  // int, long and packed subtracts at and inside the extremes
  task automatic test_sub;
    o = sssu_pkg::SSSU_OP_SUB32;
    run(40'h5A2E51A3, 40'h802A3FA2, 40'h7FFFFFFF, 1'b1);
    run(40'h436771F2, 40'h5A2E51A3, 40'hE939204F, 1'b0);
    o = sssu_pkg::SSSU_OP_SUB40;
    run(40'h8000000000, 40'h1, 40'h8000000000, 1'b1);
    o = sssu_pkg::SSSU_OP_SUB2;
    run(40'h00070005, 40'hFFFFFFFF, 40'h00080006, 1'b0);
    run(40'h80007FFF, 40'h0001FFFF, 40'h80007FFF, 1'b0);
  endtask
  // failed condition: register keeps last value, flag stays clear
  task automatic test_nop;
    o = sssu_pkg::SSSU_OP_SUB32;
    run(40'h5A2E51A3, 40'h802A3FA2, 40'h80007FFF, 1'b0, 1'b0);
  endtask
  // verdict and end of run
  task automatic results;
    $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog, far beyond the roughly 75 cycles needed
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
  // reset for three cycles, then the scenarios
  initial begin
    arst_n = 1'b0;
    op = sssu_pkg::SSSU_OP_NONE;
    o = sssu_pkg::SSSU_OP_NONE;
    {cond_pass, sat_clr, src1, src2, dst_idx} = '0;
    repeat (3) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    test_shift();
    test_sub();
    test_nop();
    results();
  end
endmodule
